// [evte_editor.sv]
// evte_editor: egress vlan tag edit decision for a three-port switch
// assumes: one header descriptor per packet from the fabric on clk; the
// transmit mac applies the returned action; apb master on the same clock
//
// How it works
// R1: dumb port passes regular packets, strips special tag from external mii port.
// R2: access port strips every tag, special tags from external mii included.
// R3: hybrid port inserts, removes or changes tags per its control bits.
// R4: cpu port adds a special tag naming the source port.
// R5: hybrid control bits are ignored unless the port is hybrid.
// R6: select clear uses ingress vid/priority, set uses egress defaults.
// R7: insert bit adds a tag to untagged packets with selected values.
// R8: insertion also needs the default vid's un-tag flag clear.
// R9: change-vid overwrites vid of regular tagged packets with selected vid.
// R10: vid change of regular tagged packets also needs change-tag.
// R11: un-tag flag of incoming vid removes the tag instead of changing vid.
// R12: priority-tagged packets always get the selected vid.
// R13: change-priority overwrites priority of regular and priority tagged packets.
// R14: regular tagged priority change needs change-tag; priority-tagged does not.
// R15: un-tag flag of incoming vid removes the tag instead of new priority.
// R16: change-tag only affects regular tagged packets.
// R17: three identical groups at bits 22:16, 14:8, 6:0; all reset zero.
// R18: reserved bits 31:23, 15 and 7 read zero, writes ignored.
`timescale 1ns/10ps
`default_nettype none

module evte_editor
    import evte_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // apb register slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // packet descriptor from the fabric
    input  wire logic                  pkt_in_valid,
    output logic                       pkt_in_ready,
    input  wire logic [1:0]            pkt_egress_port,
    input  wire logic [1:0]            pkt_src_port,
    input  wire evte_pkg::evte_tag_kind_t pkt_tag_kind,
    input  wire logic [11:0]           pkt_tag_vid,
    input  wire logic [2:0]            pkt_tag_prio,
    input  wire logic                  pkt_untag_in_vid,
    input  wire logic                  pkt_untag_dflt_vid,
    input  wire logic [11:0]           ingress_dflt_vid,
    input  wire logic [2:0]            ingress_prio,
    input  wire logic [11:0]           egress_dflt_vid,
    input  wire logic [2:0]            egress_dflt_prio,
    // edit decision toward the transmit mac
    output logic                       edit_valid,
    input  wire logic                  edit_ready,
    output evte_pkg::evte_action_t     edit_action,
    output logic      [11:0]           edit_vid,
    output logic      [2:0]            edit_prio,
    output logic      [1:0]            edit_src_port,
    output logic      [1:0]            edit_port
);
    import evte_pkg::*;

    // ------------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------------
    logic [31:0] policy_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        hit;
    logic        setup;
    logic        wr_commit;

    assign hit       = (paddr == EVTE_POLICY_ADDR);
    assign setup     = psel && !penable;
    assign wr_commit = psel && penable && pready_ff && pwrite && hit;

    // answer prepared at setup so pready stands in the first access cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= EVTE_BAD_READ_DATA;
        end
        else
        begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !hit;
            if (setup)
                prdata_ff <= hit ? (policy_ff & EVTE_POLICY_MASK) : EVTE_BAD_READ_DATA;  // R18
        end
    end

    // policy register, reserved bits never stored
    always_ff @(posedge clk)
    begin
        if (rst)
            policy_ff <= EVTE_POLICY_RESET;                  // R17
        else if (wr_commit)
            policy_ff <= pwdata & EVTE_POLICY_MASK;          // R18
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ------------------------------------------------------------------
    // per-port control group selection
    // ------------------------------------------------------------------
    logic [EVTE_GROUP_W-1:0] grp;
    evte_port_type_t         ptype;
    logic                    sel_egress;
    logic                    ins_en;
    logic                    chg_vid;
    logic                    chg_pri;
    logic                    chg_tag;
    logic                    port_ok;

    // a fourth port number has no group; treat it as dumb
    always_comb
    begin
        port_ok = (pkt_egress_port < 2'(EVTE_NUM_PORTS));
        grp     = '0;
        if (port_ok)
            grp = policy_ff[pkt_egress_port * EVTE_PORT_STRIDE +: EVTE_GROUP_W];  // R17
    end

    assign ptype      = evte_port_type_t'(grp[EVTE_TYPE_LSB +: 2]);
    assign sel_egress = grp[EVTE_SEL_BIT];
    assign ins_en     = grp[EVTE_INSERT_BIT];
    assign chg_vid    = grp[EVTE_CHG_VID_BIT];
    assign chg_pri    = grp[EVTE_CHG_PRI_BIT];
    assign chg_tag    = grp[EVTE_CHG_TAG_BIT];

    // ------------------------------------------------------------------
    // edit decision
    // ------------------------------------------------------------------
    evte_action_t nxt_action;
    logic [11:0]  nxt_vid;
    logic [2:0]   nxt_prio;
    logic [11:0]  sel_vid;
    logic [2:0]   sel_prio;

    assign sel_vid  = sel_egress ? egress_dflt_vid  : ingress_dflt_vid;    // R6
    assign sel_prio = sel_egress ? egress_dflt_prio : ingress_prio;        // R6

    // control bits are only looked at inside the hybrid branch
    always_comb
    begin
        nxt_action = EVTE_ACT_PASS;
        nxt_vid    = pkt_tag_vid;
        nxt_prio   = pkt_tag_prio;
        unique case (ptype)
            EVTE_TYPE_DUMB:
            begin
                if (pkt_tag_kind == EVTE_KIND_SPECIAL)
                    nxt_action = EVTE_ACT_STRIP;                         // R1
            end
            EVTE_TYPE_ACCESS:
            begin
                if (pkt_tag_kind != EVTE_KIND_UNTAGGED)
                    nxt_action = EVTE_ACT_STRIP;                         // R2
            end
            EVTE_TYPE_HYBRID:                                            // R3 R5
            begin
                unique case (pkt_tag_kind)
                    EVTE_KIND_UNTAGGED:
                    begin
                        if (ins_en && !pkt_untag_dflt_vid)               // R7 R8
                        begin
                            nxt_action = EVTE_ACT_INSERT;
                            nxt_vid    = sel_vid;
                            nxt_prio   = sel_prio;
                        end
                    end
                    EVTE_KIND_REGULAR:
                    begin
                        // change-tag gates both kinds of change here
                        if (chg_tag && (chg_vid || chg_pri))             // R10 R14 R16
                        begin
                            if (pkt_untag_in_vid)
                                nxt_action = EVTE_ACT_STRIP;             // R11 R15
                            else
                            begin
                                nxt_action = EVTE_ACT_REWRITE;
                                if (chg_vid)
                                    nxt_vid = sel_vid;                   // R9
                                if (chg_pri)
                                    nxt_prio = sel_prio;                 // R13
                            end
                        end
                    end
                    EVTE_KIND_PRIO:
                    begin
                        // vid replaced unless the tag is stripped; change-tag plays no part
                        if (pkt_untag_in_vid)
                            nxt_action = EVTE_ACT_STRIP;                 // R11 R15
                        else
                        begin
                            nxt_action = EVTE_ACT_REWRITE;
                            nxt_vid    = sel_vid;                        // R12 R16
                            if (chg_pri)
                                nxt_prio = sel_prio;                     // R13 R14
                        end
                    end
                    EVTE_KIND_SPECIAL:
                        nxt_action = EVTE_ACT_STRIP;  // special tag never leaves a hybrid port
                endcase
            end
            EVTE_TYPE_CPU:
                nxt_action = EVTE_ACT_SPECIAL;                           // R4
        endcase
    end

    // ------------------------------------------------------------------
    // descriptor handshake, one packet in flight
    // ------------------------------------------------------------------
    logic         accept;
    logic         in_ready_ff;
    logic         edit_valid_ff;
    evte_action_t edit_action_ff;
    logic [11:0]  edit_vid_ff;
    logic [2:0]   edit_prio_ff;
    logic [1:0]   edit_src_ff;
    logic [1:0]   edit_port_ff;

    assign accept = pkt_in_valid && in_ready_ff;

    // registered ready costs a bubble but keeps every output on a flop
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            in_ready_ff   <= 1'b1;
            edit_valid_ff <= 1'b0;
        end
        else if (accept)
        begin
            in_ready_ff   <= 1'b0;
            edit_valid_ff <= 1'b1;
        end
        else if (edit_valid_ff && edit_ready)
        begin
            in_ready_ff   <= 1'b1;
            edit_valid_ff <= 1'b0;
        end
    end

    // decision captured at accept and held until taken
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            edit_action_ff <= EVTE_ACT_PASS;
            edit_vid_ff    <= '0;
            edit_prio_ff   <= '0;
            edit_src_ff    <= '0;
            edit_port_ff   <= '0;
        end
        else if (accept)
        begin
            edit_action_ff <= nxt_action;
            edit_vid_ff    <= nxt_vid;
            edit_prio_ff   <= nxt_prio;
            edit_src_ff    <= pkt_src_port;                              // R4
            edit_port_ff   <= pkt_egress_port;
        end
    end

    assign pkt_in_ready  = in_ready_ff;
    assign edit_valid    = edit_valid_ff;
    assign edit_action   = edit_action_ff;
    assign edit_vid      = edit_vid_ff;
    assign edit_prio     = edit_prio_ff;
    assign edit_src_port = edit_src_ff;
    assign edit_port     = edit_port_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_dumb_pass;
        accept && port_ok && ptype == EVTE_TYPE_DUMB && pkt_tag_kind != EVTE_KIND_SPECIAL
            |=> edit_valid && edit_action == EVTE_ACT_PASS;
    endproperty
    a_dumb_pass: assert property (p_dumb_pass) else $error("dumb port altered a packet"); // R1

    property p_access_strip;
        accept && ptype == EVTE_TYPE_ACCESS && pkt_tag_kind != EVTE_KIND_UNTAGGED
            |=> edit_action == EVTE_ACT_STRIP;
    endproperty
    a_access_strip: assert property (p_access_strip) else $error("access tag kept"); // R2

    property p_cpu_special;
        accept && ptype == EVTE_TYPE_CPU
            |=> edit_action == EVTE_ACT_SPECIAL && edit_src_port == $past(pkt_src_port);
    endproperty
    a_cpu_special: assert property (p_cpu_special) else $error("cpu tag missing"); // R4

    property p_non_hybrid_quiet;
        accept && ptype != EVTE_TYPE_HYBRID
            |=> edit_action != EVTE_ACT_INSERT && edit_action != EVTE_ACT_REWRITE;
    endproperty
    a_non_hybrid_quiet: assert property (p_non_hybrid_quiet) else $error("bits used"); // R5

    property p_insert;
        accept && ptype == EVTE_TYPE_HYBRID && pkt_tag_kind == EVTE_KIND_UNTAGGED
            |=> (edit_action == EVTE_ACT_INSERT) == $past(ins_en && !pkt_untag_dflt_vid);
    endproperty
    a_insert: assert property (p_insert) else $error("insert decision wrong"); // R7

    property p_sel_vid;
        accept && nxt_action == EVTE_ACT_INSERT
            |=> edit_vid == $past(sel_egress ? egress_dflt_vid : ingress_dflt_vid);
    endproperty
    a_sel_vid: assert property (p_sel_vid) else $error("inserted vid wrong"); // R6

    property p_reg_needs_chg_tag;
        accept && ptype == EVTE_TYPE_HYBRID && pkt_tag_kind == EVTE_KIND_REGULAR && !chg_tag
            |=> edit_action == EVTE_ACT_PASS;
    endproperty
    a_reg_needs_chg_tag: assert property (p_reg_needs_chg_tag) else $error("ungated"); // R10

    property p_untag_strip;
        accept && ptype == EVTE_TYPE_HYBRID && pkt_untag_in_vid
            && (pkt_tag_kind == EVTE_KIND_PRIO
                || (pkt_tag_kind == EVTE_KIND_REGULAR && chg_tag && (chg_vid || chg_pri)))
            |=> edit_action == EVTE_ACT_STRIP;
    endproperty
    a_untag_strip: assert property (p_untag_strip) else $error("tag not removed"); // R11

    property p_prio_vid;
        accept && ptype == EVTE_TYPE_HYBRID && pkt_tag_kind == EVTE_KIND_PRIO
            && !pkt_untag_in_vid
            |=> edit_action == EVTE_ACT_REWRITE && edit_vid == $past(sel_vid);
    endproperty
    a_prio_vid: assert property (p_prio_vid) else $error("priority-tag vid kept"); // R12

    property p_hold;
        edit_valid && !edit_ready |=> edit_valid && $stable(edit_action) && $stable(edit_vid);
    endproperty
    a_hold: assert property (p_hold) else $error("decision dropped before taken");

    property p_reserved_zero;
        psel && penable && pready && !pwrite |-> (prdata & ~EVTE_POLICY_MASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // R18

    property p_write_lands;
        wr_commit |=> policy_ff == $past(pwdata & EVTE_POLICY_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("policy write lost"); // R17

    c_insert:   cover property (accept && nxt_action == EVTE_ACT_INSERT);
    c_rewrite:  cover property (accept && nxt_action == EVTE_ACT_REWRITE);
    c_special:  cover property (accept && nxt_action == EVTE_ACT_SPECIAL);
    c_stall:    cover property (edit_valid && !edit_ready ##1 edit_valid && edit_ready);

endmodule : evte_editor

`default_nettype wire

// [evte_pkg.sv]
// evte_pkg: constants, field layout and types of the egress vlan tag editor
// assumes: shared by the editor top module and the bench; no timing of its own
package evte_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] EVTE_POLICY_INDEX  = 16'h1C0C;           // register number
    localparam logic [15:0] EVTE_POLICY_ADDR   = EVTE_POLICY_INDEX << 2;  // byte address
    localparam logic [31:0] EVTE_POLICY_RESET  = 32'h0000_0000;
    localparam logic [31:0] EVTE_POLICY_MASK   = 32'h007F_7F7F;      // writable bits
    localparam logic [31:0] EVTE_BAD_READ_DATA = 32'h0000_0000;

    // ------------------------------------------------------------------
    // per-port control group layout (port n sits at n * stride)
    // ------------------------------------------------------------------
    localparam int unsigned EVTE_PORT_STRIDE = 8;
    localparam int unsigned EVTE_TYPE_LSB    = 0;
    localparam int unsigned EVTE_CHG_TAG_BIT = 2;
    localparam int unsigned EVTE_CHG_PRI_BIT = 3;
    localparam int unsigned EVTE_CHG_VID_BIT = 4;
    localparam int unsigned EVTE_INSERT_BIT  = 5;
    localparam int unsigned EVTE_SEL_BIT     = 6;
    localparam int unsigned EVTE_GROUP_W     = 7;
    localparam int unsigned EVTE_NUM_PORTS   = 3;

    // ------------------------------------------------------------------
    // port numbering and field widths
    // ------------------------------------------------------------------
    localparam logic [1:0]  EVTE_EXT_MII_PORT = 2'h0;   // external mii port
    localparam int unsigned EVTE_VID_W        = 12;
    localparam int unsigned EVTE_PRIO_W       = 3;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EVTE_TYPE_DUMB   = 2'b00,
        EVTE_TYPE_ACCESS = 2'b01,
        EVTE_TYPE_HYBRID = 2'b10,
        EVTE_TYPE_CPU    = 2'b11
    } evte_port_type_t;

    typedef enum logic [1:0] {
        EVTE_KIND_UNTAGGED = 2'b00,
        EVTE_KIND_REGULAR  = 2'b01,
        EVTE_KIND_PRIO     = 2'b10,
        EVTE_KIND_SPECIAL  = 2'b11
    } evte_tag_kind_t;

    typedef enum logic [2:0] {
        EVTE_ACT_PASS    = 3'b000,
        EVTE_ACT_STRIP   = 3'b001,
        EVTE_ACT_INSERT  = 3'b010,
        EVTE_ACT_REWRITE = 3'b011,
        EVTE_ACT_SPECIAL = 3'b100
    } evte_action_t;

endpackage : evte_pkg

// [evte_mac_model.sv]
// evte_mac_model: transmit mac model that accepts edit decisions
// assumes: same clock and reset as the editor; the bench sets slow to stall
`timescale 1ns/10ps
`default_nettype none

module evte_mac_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // mode chosen by the bench
    input  wire logic slow,
    // handshake toward the editor
    output logic      edit_ready
);
    // ------------------------------------------------------------------
    // acceptance pattern
    // ------------------------------------------------------------------
    logic [1:0] phase_ff;

    // free-running phase; slow mode accepts one cycle in four
    always_ff @(posedge clk)
    begin
        if (rst)
            phase_ff <= 2'h0;
        else
            phase_ff <= phase_ff + 2'h1;
    end

    // registered ready, so a stalled decision must stay put at the editor
    always_ff @(posedge clk)
    begin
        if (rst)
            edit_ready <= 1'b0;
        else
            edit_ready <= !slow || (phase_ff == 2'h2);
    end
endmodule : evte_mac_model
`default_nettype wire

// [tb_egress_vlan_tag_editor.sv]
// tb_egress_vlan_tag_editor: self-checking bench for the egress tag editor
// assumes: evte_pkg, evte_editor and evte_mac_model are compiled before it
`timescale 1ns/10ps
`default_nettype none

module tb_egress_vlan_tag_editor;
    import evte_pkg::*;

    // ------------------------------------------------------------------
    // signals and short names for the codes
    // ------------------------------------------------------------------
    localparam evte_tag_kind_t UT = EVTE_KIND_UNTAGGED;
    localparam evte_tag_kind_t RG = EVTE_KIND_REGULAR;
    localparam evte_tag_kind_t PT = EVTE_KIND_PRIO;
    localparam evte_tag_kind_t SP = EVTE_KIND_SPECIAL;
    localparam logic [11:0]    IV = 12'h123;
    localparam logic [2:0]     IP = 3'h5;
    localparam logic [11:0]    EV = 12'hABC;
    localparam logic [2:0]     EP = 3'h2;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           slow = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [15:0]    paddr = 16'h0;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata;
    logic [31:0]    rd;
    logic           pready;
    logic           pslverr;
    logic           err;
    logic           pkt_in_valid = 1'b0;
    logic           pkt_in_ready;
    logic           untag_in = 1'b0;
    logic           untag_dflt = 1'b0;
    logic [1:0]     eg = 2'h0;
    logic [1:0]     src = 2'h0;
    evte_tag_kind_t kind = EVTE_KIND_UNTAGGED;
    logic [11:0]    tvid = 12'h0;
    logic [2:0]     tprio = 3'h0;
    logic           edit_valid;
    logic           edit_ready;
    evte_action_t   edit_action;
    logic [11:0]    edit_vid;
    logic [2:0]     edit_prio;
    logic [1:0]     edit_src_port;
    logic [1:0]     edit_port;
    int             error_cnt = 0;
    int             checks = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    evte_editor DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pkt_in_valid(pkt_in_valid), .pkt_in_ready(pkt_in_ready), .pkt_egress_port(eg),
        .pkt_src_port(src), .pkt_tag_kind(kind), .pkt_tag_vid(tvid), .pkt_tag_prio(tprio),
        .pkt_untag_in_vid(untag_in), .pkt_untag_dflt_vid(untag_dflt),
        .ingress_dflt_vid(IV), .ingress_prio(IP), .egress_dflt_vid(EV),
        .egress_dflt_prio(EP), .edit_valid(edit_valid), .edit_ready(edit_ready),
        .edit_action(edit_action), .edit_vid(edit_vid), .edit_prio(edit_prio),
        .edit_src_port(edit_src_port), .edit_port(edit_port));

    evte_mac_model mac (.clk(clk), .rst(rst), .slow(slow), .edit_ready(edit_ready));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; no wait-state count assumed, only a bounded wait
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // answer taken at the rising edge where pready is sampled high
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one descriptor in, one decision out, compared as it is taken
    task automatic pkt(input logic [1:0] e, s, input evte_tag_kind_t k,
        input logic [11:0] v, input logic [2:0] p, input logic ui, ud,
        input evte_action_t xa, input logic [11:0] xv, input logic [2:0] xp);
        int n;
        @(posedge clk);
        pkt_in_valid <= 1'b1;
        eg <= e;
        src <= s;
        kind <= k;
        tvid <= v;
        tprio <= p;
        untag_in <= ui;
        untag_dflt <= ud;
        // descriptor held until the edge where ready is sampled high
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pkt_in_ready !== 1'b1 && n < 100);
        if (pkt_in_ready !== 1'b1)
            error_cnt++;
        pkt_in_valid <= 1'b0;
        // decision compared at the edge where the mac takes it
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!(edit_valid === 1'b1 && edit_ready === 1'b1) && n < 100);
        chk({10'h0, edit_action, edit_vid, edit_prio, edit_src_port, edit_port},
            {10'h0, xa, xv, xp, s, e});
        @(posedge clk);
    endtask : pkt

    task automatic give_verdict();
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, EVTE_POLICY_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, EVTE_POLICY_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, EVTE_POLICY_ADDR, 32'h0);
        chk(rd, 32'h007F_7F7F);
        // neighbour word is refused and must leave the policy alone
        apb(1'b1, 16'h7034, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, EVTE_POLICY_ADDR, 32'h0);
        chk(rd, 32'h007F_7F7F);
        chk({31'h0, err}, 32'h0);
        // port 0 hybrid egress-select, port 1 dumb with stray bits, port 2 cpu
        apb(1'b1, EVTE_POLICY_ADDR, 32'h0003_7C7E);
        pkt(0, 1, UT, 12'h055, 1, 0, 0, EVTE_ACT_INSERT, EV, EP);
        pkt(0, 1, UT, 12'h055, 1, 0, 1, EVTE_ACT_PASS, 12'h055, 1);
        pkt(0, 2, RG, 12'h055, 1, 0, 0, EVTE_ACT_REWRITE, EV, EP);
        pkt(0, 2, RG, 12'h055, 1, 1, 0, EVTE_ACT_STRIP, 12'h055, 1);
        pkt(0, 2, PT, 12'h000, 1, 0, 0, EVTE_ACT_REWRITE, EV, EP);
        pkt(1, 2, UT, 12'h055, 1, 0, 0, EVTE_ACT_PASS, 12'h055, 1);
        pkt(1, 2, RG, 12'h055, 1, 0, 0, EVTE_ACT_PASS, 12'h055, 1);
        pkt(1, 0, SP, 12'h055, 1, 0, 0, EVTE_ACT_STRIP, 12'h055, 1);
        pkt(2, 1, RG, 12'h055, 1, 0, 0, EVTE_ACT_SPECIAL, 12'h055, 1);
        pkt(3, 0, SP, 12'h055, 1, 0, 0, EVTE_ACT_STRIP, 12'h055, 1);
        // second layout with a stalling mac; ingress-select everywhere
        slow <= 1'b1;
        apb(1'b1, EVTE_POLICY_ADDR, 32'h0001_1A16);
        pkt(0, 1, RG, 12'h055, 1, 0, 0, EVTE_ACT_REWRITE, IV, 1);
        pkt(1, 0, RG, 12'h055, 1, 0, 0, EVTE_ACT_PASS, 12'h055, 1);
        pkt(1, 0, PT, 12'h000, 1, 0, 0, EVTE_ACT_REWRITE, IV, IP);
        pkt(1, 0, PT, 12'h000, 1, 1, 0, EVTE_ACT_STRIP, 12'h000, 1);
        pkt(2, 1, RG, 12'h055, 1, 0, 0, EVTE_ACT_STRIP, 12'h055, 1);
        pkt(2, 0, SP, 12'h055, 1, 0, 0, EVTE_ACT_STRIP, 12'h055, 1);
        pkt(2, 1, UT, 12'h055, 1, 0, 0, EVTE_ACT_PASS, 12'h055, 1);
        give_verdict();
    end

    // watchdog: the tests need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule : tb_egress_vlan_tag_editor
`default_nettype wire
